/* src/tsd_top.sv */
// Decodes one instruction per cycle and registers its exception result.
// Assumes the pipeline supplies operand values read for the instruction.
`timescale 1ns/1ps
`include "tsd_map.svh"
module tsd_top (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst,
  // Request from pipeline
  input  wire tsd_pkg::tsd_req_t req,
  // Exception signal to exception logic
  output tsd_pkg::tsd_resp_t     resp
);
  wire logic [5:0]  major = req.instr[`TSD_MAJOR_HI:`TSD_MAJOR_LO];
  wire logic [5:0]  func  = req.instr[`TSD_FUNC_HI:`TSD_FUNC_LO];
  wire logic [4:0]  sub   = req.instr[`TSD_SUB_HI:`TSD_SUB_LO];
  // Only function, major and sub fields are decoded; code bits stay unseen
  wire logic        function_class_major_op     = (major == `TSD_OP_FUNC_CLASS);
  wire logic        register_immediate_major_op = (major == `TSD_OP_REG_IMM);
  wire logic        system_call_op    = function_class_major_op
                                        && (func == `TSD_FN_SYSTEM_CALL_OP);
  wire logic        trap_equal_op     = function_class_major_op
                                        && (func == `TSD_FN_TRAP_EQ);
  wire logic        trap_ge_signed_op = function_class_major_op
                                        && (func == `TSD_FN_TRAP_GE);
  wire logic        trap_equal_imm_op = register_immediate_major_op
                                        && (sub == `TSD_SUB_TRAP_EQI);
  // Shared by the datapath and the shadow decode below
  function automatic logic [63:0] tsd_sext16(input logic [`TSD_IMM_W-1:0] imm);
    return {{`TSD_IMM_PAD{imm[`TSD_IMM_W-1]}}, imm};
  endfunction

  wire logic [63:0] imm_wide = tsd_sext16(req.instr[`TSD_IMM_HI:`TSD_IMM_LO]);
  // Immediate form compares against the widened immediate instead of rt
  wire logic [63:0] rhs = trap_equal_imm_op ? imm_wide : req.rt_val;
  wire logic        cmp_eq;
  wire logic        cmp_ge;

  tsd_compare u_cmp (
    .lhs       (req.rs_val),
    .rhs       (rhs),
    .equal     (cmp_eq),
    .ge_signed (cmp_ge)
  );

  wire logic trap_hit = (trap_equal_op && cmp_eq)
                     || (trap_equal_imm_op && cmp_eq)
                     || (trap_ge_signed_op && cmp_ge);
  tsd_pkg::tsd_resp_t next_resp;

  always_comb begin
    next_resp.valid = req.valid;
    next_resp.exc   = tsd_pkg::TSD_EXC_NONE;
    if (req.valid && system_call_op) begin
      next_resp.exc = tsd_pkg::TSD_EXC_SYSTEM_CALL_OP;
    end else if (req.valid && trap_hit) begin
      next_resp.exc = tsd_pkg::TSD_EXC_TRAP;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      resp <= `TSD_RESP_IDLE;
    end else begin
      resp <= next_resp;
    end
  end

  // Assertions
  AST_SYSTEM_CALL_OP: assert property (@(posedge mclk) disable iff (rst)
    req.valid && req.instr[31:26] == 6'h00 && req.instr[5:0] == 6'h0c
    |=> resp.exc == tsd_pkg::TSD_EXC_SYSTEM_CALL_OP) else $error("system_call_op missed");
  AST_SYSTEM_CALL_OP_UNCOND: assert property (@(posedge mclk) disable iff (rst)
    req.valid && system_call_op |=> resp.valid && resp.exc != tsd_pkg::TSD_EXC_NONE)
    else $error("system_call_op not raised");
  AST_CODE_IGNORED: assert property (@(posedge mclk) disable iff (rst)
    req.valid && system_call_op |=> resp.exc == tsd_pkg::TSD_EXC_SYSTEM_CALL_OP)
    else $error("system_call_op code affected result");
  AST_TEQ: assert property (@(posedge mclk) disable iff (rst)
    req.valid && trap_equal_op
    |=> (resp.exc == tsd_pkg::TSD_EXC_TRAP) == $past(req.rs_val == req.rt_val))
    else $error("reg equal trap wrong");
  AST_TRAP_EQUAL_IMM_OP: assert property (@(posedge mclk) disable iff (rst)
    req.valid && trap_equal_imm_op
    |=> (resp.exc == tsd_pkg::TSD_EXC_TRAP)
        == $past(req.rs_val == {{48{req.instr[15]}}, req.instr[15:0]}))
    else $error("imm equal trap wrong");
  AST_TGE: assert property (@(posedge mclk) disable iff (rst)
    req.valid && trap_ge_signed_op
    |=> (resp.exc == tsd_pkg::TSD_EXC_TRAP) == $past($signed(req.rs_val) >= $signed(req.rt_val)))
    else $error("signed ge trap wrong");
  AST_CODE_FREE: assert property (@(posedge mclk) disable iff (rst)
    req.valid && (trap_equal_op || trap_ge_signed_op) && req.rs_val == req.rt_val
    |=> resp.exc == tsd_pkg::TSD_EXC_TRAP) else $error("code field changed trap");
  AST_WIDE: assert property (@(posedge mclk) disable iff (rst)
    req.valid && trap_equal_op && req.rs_val[31:0] == req.rt_val[31:0]
    && req.rs_val[63:32] != req.rt_val[63:32]
    |=> resp.exc == tsd_pkg::TSD_EXC_NONE) else $error("upper bits not compared");
  AST_NO_VALID_NO_EXC: assert property (@(posedge mclk) disable iff (rst)
    !req.valid |=> !resp.valid && resp.exc == tsd_pkg::TSD_EXC_NONE)
    else $error("exception without request");
  COV_SYSTEM_CALL_OP: cover property (@(posedge mclk) disable iff (rst)
    resp.exc == tsd_pkg::TSD_EXC_SYSTEM_CALL_OP);
  COV_TRAP_IMM: cover property (@(posedge mclk) disable iff (rst)
    req.valid && trap_equal_imm_op ##1 resp.exc == tsd_pkg::TSD_EXC_TRAP);
  COV_TGE_NOTRAP: cover property (@(posedge mclk) disable iff (rst)
    req.valid && trap_ge_signed_op ##1 resp.exc == tsd_pkg::TSD_EXC_NONE);
  COV_TEQ_TRAP: cover property (@(posedge mclk) disable iff (rst)
    req.valid && trap_equal_op ##1 resp.exc == tsd_pkg::TSD_EXC_TRAP);
  COV_BACK_TO_BACK: cover property (@(posedge mclk) disable iff (rst)
    req.valid ##1 req.valid && resp.valid);

  // Shadow decode, built straight from the raw fields.
  // A slip in the named decode wires shows up as a mismatch with resp.
  wire logic [5:0]  ref_major  = req.instr[`TSD_MAJOR_HI:`TSD_MAJOR_LO];
  wire logic [5:0]  ref_func   = req.instr[`TSD_FUNC_HI:`TSD_FUNC_LO];
  wire logic [4:0]  ref_sub    = req.instr[`TSD_SUB_HI:`TSD_SUB_LO];
  wire logic        ref_class0 = (ref_major == `TSD_OP_FUNC_CLASS);
  wire logic        ref_class1 = (ref_major == `TSD_OP_REG_IMM);
  wire logic        ref_sys    = ref_class0 && (ref_func == `TSD_FN_SYSTEM_CALL_OP);
  wire logic        ref_teq    = ref_class0 && (ref_func == `TSD_FN_TRAP_EQ)
                                 && (req.rs_val == req.rt_val);
  wire logic        ref_trap_equal_imm_op   = ref_class1 && (ref_sub == `TSD_SUB_TRAP_EQI)
                                 && (req.rs_val == tsd_sext16(req.instr[`TSD_IMM_HI:`TSD_IMM_LO]));
  wire logic        ref_tge    = ref_class0 && (ref_func == `TSD_FN_TRAP_GE)
                                 && ($signed(req.rs_val) >= $signed(req.rt_val));
  wire logic        ref_trap   = ref_teq || ref_trap_equal_imm_op || ref_tge;
  wire tsd_pkg::tsd_exc_t ref_exc = !req.valid ? tsd_pkg::TSD_EXC_NONE
                                  : ref_sys    ? tsd_pkg::TSD_EXC_SYSTEM_CALL_OP
                                  : ref_trap   ? tsd_pkg::TSD_EXC_TRAP
                                  : tsd_pkg::TSD_EXC_NONE;
  tsd_pkg::tsd_exc_t ref_exc_q;
  logic              ref_valid_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      ref_exc_q   <= tsd_pkg::TSD_EXC_NONE;
      ref_valid_q <= 1'b0;
    end else begin
      ref_exc_q   <= ref_exc;
      ref_valid_q <= req.valid;
    end
  end

  // Whole-result check against the shadow; catches priority slips too
  AST_REF_MATCH: assert property (@(posedge mclk) disable iff (rst)
    resp.exc == ref_exc_q && resp.valid == ref_valid_q)
    else $error("result differs from shadow decode");
  // Held reset must leave the exception line quiet
  AST_RESET_IDLE: assert property (@(posedge mclk)
    rst |=> resp == `TSD_RESP_IDLE)
    else $error("result not idle after reset");
  AST_VALID_ECHO: assert property (@(posedge mclk) disable iff (rst)
    1'b1 |=> resp.valid == $past(req.valid))
    else $error("valid not echoed one cycle later");
  AST_EXC_LEGAL: assert property (@(posedge mclk) disable iff (rst)
    resp.exc != `TSD_EXC_UNUSED)
    else $error("unused exception code");
  // Only the covered encodings may raise anything
  AST_TRAP_NEEDS_DECODE: assert property (@(posedge mclk) disable iff (rst)
    req.valid && !(trap_equal_op || trap_equal_imm_op || trap_ge_signed_op)
    |=> resp.exc != tsd_pkg::TSD_EXC_TRAP)
    else $error("trap without trap encoding");
  AST_SYSTEM_CALL_OP_NEEDS_DECODE: assert property (@(posedge mclk) disable iff (rst)
    req.valid && !system_call_op |=> resp.exc != tsd_pkg::TSD_EXC_SYSTEM_CALL_OP)
    else $error("system call without its encoding");
  AST_TEQ_UNEQUAL: assert property (@(posedge mclk) disable iff (rst)
    req.valid && trap_equal_op && req.rs_val != req.rt_val
    |=> resp.exc == tsd_pkg::TSD_EXC_NONE)
    else $error("unequal registers trapped");
  // Immediate form must not look at the second register at all
  AST_TRAP_EQUAL_IMM_OP_NO_RT: assert property (@(posedge mclk) disable iff (rst)
    req.valid && trap_equal_imm_op && req.rs_val == imm_wide && req.rt_val != imm_wide
    |=> resp.exc == tsd_pkg::TSD_EXC_TRAP)
    else $error("immediate trap used second register");
  AST_TRAP_EQUAL_IMM_OP_WIDE: assert property (@(posedge mclk) disable iff (rst)
    req.valid && trap_equal_imm_op && req.rs_val[15:0] == req.instr[15:0]
    && req.rs_val[63:16] != {48{req.instr[15]}}
    |=> resp.exc == tsd_pkg::TSD_EXC_NONE)
    else $error("immediate upper bits not compared");
  // Sign matters: negative first operand never reaches a positive second
  AST_TGE_SIGN: assert property (@(posedge mclk) disable iff (rst)
    req.valid && trap_ge_signed_op && req.rs_val[63] && !req.rt_val[63]
    |=> resp.exc == tsd_pkg::TSD_EXC_NONE)
    else $error("signed compare treated as unsigned");
  AST_TGE_POS_NEG: assert property (@(posedge mclk) disable iff (rst)
    req.valid && trap_ge_signed_op && !req.rs_val[63] && req.rt_val[63]
    |=> resp.exc == tsd_pkg::TSD_EXC_TRAP)
    else $error("positive over negative not trapped");
  // Nonzero code bits 15..6 must not block an equal-register trap
  AST_CODE_BITS_FREE: assert property (@(posedge mclk) disable iff (rst)
    req.valid && trap_equal_op && req.instr[15:6] != 10'h000 && req.rs_val == req.rt_val
    |=> resp.exc == tsd_pkg::TSD_EXC_TRAP)
    else $error("nonzero code field blocked trap");
  AST_SYSTEM_CALL_OP_PARAM_FREE: assert property (@(posedge mclk) disable iff (rst)
    req.valid && system_call_op && req.instr[25:6] != 20'h00000
    |=> resp.exc == tsd_pkg::TSD_EXC_SYSTEM_CALL_OP && resp.valid)
    else $error("parameter field changed system call");
endmodule

/* src/tsd_map.svh */
// Encodings and field positions for the trap and system-call decoder.
// Assumes a 32-bit instruction word and 64-bit general registers.
`ifndef TSD_MAP_SVH
`define TSD_MAP_SVH
`define TSD_MAJOR_HI       31
`define TSD_MAJOR_LO       26
`define TSD_FUNC_HI        5
`define TSD_FUNC_LO        0
`define TSD_SUB_HI         20
`define TSD_SUB_LO         16
`define TSD_RS_HI          25
`define TSD_RS_LO          21
`define TSD_RT_HI          20
`define TSD_RT_LO          16
`define TSD_IMM_HI         15
`define TSD_IMM_LO         0
`define TSD_OP_FUNC_CLASS  6'h00
`define TSD_OP_REG_IMM     6'h01
`define TSD_FN_SYSTEM_CALL_OP     6'h0c
`define TSD_FN_TRAP_EQ     6'h34
`define TSD_FN_TRAP_GE     6'h30
`define TSD_SUB_TRAP_EQI   5'h0c
`define TSD_RESP_IDLE      3'h0
`define TSD_EXC_UNUSED     2'h3
`define TSD_IMM_W          16
`define TSD_IMM_PAD        48
`endif

/* src/tsd_pkg.sv */
// Types for the trap and system-call decoder.
// Assumes tsd_map.svh is compiled alongside.
package tsd_pkg;
  typedef struct packed {
    logic        valid;
    logic [31:0] instr;
    logic [63:0] rs_val;
    logic [63:0] rt_val;
  } tsd_req_t;

  typedef enum logic [1:0] {
    TSD_EXC_NONE    = 2'b00,
    TSD_EXC_SYSTEM_CALL_OP = 2'b01,
    TSD_EXC_TRAP    = 2'b10
  } tsd_exc_t;

  typedef struct packed {
    logic     valid;
    tsd_exc_t exc;
  } tsd_resp_t;
endpackage

/* src/tsd_compare.sv */
// Signed comparator for trap evaluation, full 64-bit operands.
// Assumes operands already widened by the caller.
`timescale 1ns/1ps
module tsd_compare (
  // Operands
  input  wire logic [63:0] lhs,
  input  wire logic [63:0] rhs,
  // Results
  output wire logic        equal,
  output wire logic        ge_signed
);
  assign equal     = (lhs == rhs);
  assign ge_signed = ($signed(lhs) >= $signed(rhs));
endmodule

/* dv/tsd_exc_sink.sv */
// Exception-logic partner: tallies exceptions it is signalled.
// Assumes resp is registered on mclk.
`timescale 1ns/1ps
module tsd_exc_sink (
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               rst,
  // Exception signal
  input  wire tsd_pkg::tsd_resp_t resp,
  // Tally, one edge behind resp
  output int                      n_exc
);
  always @(posedge mclk) begin
    if (rst) begin
      n_exc <= 0;
    end else if (resp.valid && resp.exc != tsd_pkg::TSD_EXC_NONE) begin
      n_exc <= n_exc + 1;
    end
  end
endmodule

/* dv/tsd_top_bench.sv */
// Self-checking bench for the trap and system-call decoder.
// Assumes one-cycle registered response per request.
`timescale 1ns/1ps
module tsd_top_bench;
  logic               mclk = 1'b0;
  logic               rst = 1'b1;
  tsd_pkg::tsd_req_t  req = '0;
  tsd_pkg::tsd_resp_t resp;
  int                 fail_count = 0;
  int                 n_checks = 0;
  int                 n_exc;
  int                 n_exp = 0;
  always #5 mclk = ~mclk;
  tsd_top tsd_top_i (.mclk(mclk), .rst(rst), .req(req), .resp(resp));
  tsd_exc_sink tsd_exc_sink_i (.mclk(mclk), .rst(rst), .resp(resp), .n_exc(n_exc));
  task automatic chk(input tsd_pkg::tsd_resp_t got, input tsd_pkg::tsd_resp_t exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t resp %h expected %h", $time, got, exp);
    end
  endtask
  // Valid dropped after one edge so the checked result is this request's
  task automatic run(input logic [31:0] ins, input logic [63:0] a, input logic [63:0] b,
                     input tsd_pkg::tsd_exc_t e);
    @(posedge mclk);
    req <= {1'b1, ins, a, b};
    @(posedge mclk);
    req.valid <= 1'b0;
    #1 chk(resp, {1'b1, e});
    if (e != tsd_pkg::TSD_EXC_NONE) n_exp++;
  endtask
  task automatic t_sys;
    run(32'h03ffffcc, 64'h5, 64'h6, tsd_pkg::TSD_EXC_SYSTEM_CALL_OP);
    run(32'h0000000c, 64'h0, 64'h1, tsd_pkg::TSD_EXC_SYSTEM_CALL_OP);
    $display("test system_call_op done");
  endtask
  task automatic t_teq;
    run(32'h0022fff4, 64'h8000000000000001, 64'h8000000000000001, tsd_pkg::TSD_EXC_TRAP);
    run(32'h00220034, 64'h0000000000000001, 64'h8000000000000001, tsd_pkg::TSD_EXC_NONE);
    run(32'h00220034, 64'h0000010000000007, 64'h7, tsd_pkg::TSD_EXC_NONE);
    $display("test trap equal done");
  endtask
  task automatic t_trap_equal_imm_op;
    run(32'h040cfffe, 64'hfffffffffffffffe, 64'h0, tsd_pkg::TSD_EXC_TRAP);
    run(32'h040cfffe, 64'h000000000000fffe, 64'h0, tsd_pkg::TSD_EXC_NONE);
    run(32'h040c1234, 64'h0000000000001234, 64'h9, tsd_pkg::TSD_EXC_TRAP);
    run(32'h040c1234, 64'h0000000100001234, 64'h9, tsd_pkg::TSD_EXC_NONE);
    $display("test trap equal immediate done");
  endtask
  task automatic t_tge;
    run(32'h0022fff0, 64'hffffffffffffffff, 64'h1, tsd_pkg::TSD_EXC_NONE);
    run(32'h00220030, 64'h1, 64'hffffffffffffffff, tsd_pkg::TSD_EXC_TRAP);
    run(32'h00220030, 64'h8000000000000000, 64'h8000000000000000, tsd_pkg::TSD_EXC_TRAP);
    $display("test trap greater or equal done");
  endtask
  // Neighbouring encodings must not be taken for the covered ones
  task automatic t_other;
    run(32'h0000000f, 64'h0, 64'h0, tsd_pkg::TSD_EXC_NONE);
    run(32'h00220031, 64'h3, 64'h3, tsd_pkg::TSD_EXC_NONE);
    run(32'h04080000, 64'h0, 64'h0, tsd_pkg::TSD_EXC_NONE);
    run(32'h0400000c, 64'h0, 64'h0, tsd_pkg::TSD_EXC_NONE);
    @(posedge mclk);
    #1 chk(resp, '0);
    if (n_exc !== n_exp) chk(3'h7, 3'h0);
    $display("test other encodings done");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1 chk(resp, '0);
    t_sys();
    t_teq();
    t_trap_equal_imm_op();
    t_tge();
    t_other();
    conclude();
  end
endmodule
